/* File: simd_pkg.sv */
// Package: opcodes, lane geometry and timing for the packed SIMD datapath
package simd_pkg;
  // ==========================================================
  // Operand geometry
  localparam int unsigned VEC_W   = 64;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned DWORD_W = 32;
  localparam int unsigned N_BYTES = 8;
  localparam int unsigned N_WORDS = 4;
  localparam int unsigned N_DWORDS = 2;
  localparam int unsigned OPC_W   = 16;
  // ==========================================================
  // Opcodes
  localparam logic [15:0] OPC_PACK_SB   = 16'h0f63;
  localparam logic [15:0] OPC_PACK_UB   = 16'h0f67;
  localparam logic [15:0] OPC_ADD_B     = 16'h0ffc;
  localparam logic [15:0] OPC_ADD_D     = 16'h0ffe;
  localparam logic [15:0] OPC_ADD_W     = 16'h0ffd;
  localparam logic [15:0] OPC_ADDS_SB   = 16'h0fec;
  localparam logic [15:0] OPC_ADDS_SW   = 16'h0fed;
  localparam logic [15:0] OPC_ADDS_UB   = 16'h0fdc;
  localparam logic [15:0] OPC_ADDS_UW   = 16'h0fdd;
  localparam logic [15:0] OPC_AND       = 16'h0fdb;
  localparam logic [15:0] OPC_ANDN      = 16'h0fdf;
  localparam logic [15:0] OPC_CMPEQ_B   = 16'h0f74;
  localparam logic [15:0] OPC_CMPEQ_W   = 16'h0f75;
  localparam logic [15:0] OPC_CMPEQ_D   = 16'h0f76;
  localparam logic [15:0] OPC_CMPGT_B   = 16'h0f64;
  localparam logic [15:0] OPC_CMPGT_D   = 16'h0f66;
  // ==========================================================
  // Mod field and timing
  localparam logic [1:0]  MOD_REG       = 2'h3;
  localparam int unsigned LATENCY_CYC   = 1;
  // ==========================================================
  // Operation classes
  typedef enum logic [4:0] {
    op_none, op_pack_sb, op_pack_ub, op_add_b, op_add_w, op_add_d,
    op_adds_sb, op_adds_sw, op_adds_ub, op_adds_uw, op_and, op_andn,
    op_eq_b, op_eq_w, op_eq_d, op_gt_b, op_gt_d
  } op_e;
endpackage

/* File: simd_lane_sat.sv */
// Lane adder for one byte or word lane with optional clamping
`timescale 1ns/1ps
`default_nettype none
module simd_lane_sat #(
  parameter int unsigned W = 8
) (
  // Operands
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  // Mode
  input  wire logic         sat_en,
  input  wire logic         signed_en,
  // Result
  output logic [W-1:0]      sum
);
  logic [W:0] ext;
  logic       s_ovf;
  // Extended sum exposes carry and sign overflow without crossing lanes
  always_comb begin
    ext   = {1'b0, a} + {1'b0, b};
    s_ovf = (a[W-1] == b[W-1]) && (ext[W-1] != a[W-1]);
    sum   = ext[W-1:0];
    if (sat_en && signed_en && s_ovf) begin
      sum = a[W-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
    end else if (sat_en && !signed_en && ext[W]) begin
      sum = {W{1'b1}};
    end
  end
endmodule
`default_nettype wire

/* File: simd_exec.sv */
// Packed SIMD add, pack, logic and compare execution unit
`timescale 1ns/1ps
`default_nettype none
module simd_exec
  import simd_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // Issue from decoder
  input  wire logic                      issue_valid,
  input  wire logic [simd_pkg::OPC_W-1:0] opcode,
  input  wire logic [1:0]                mod_field,
  input  wire logic [simd_pkg::VEC_W-1:0] destination_vector_register,
  input  wire logic [simd_pkg::VEC_W-1:0] source_vector_register,
  input  wire logic [simd_pkg::VEC_W-1:0] memory_operand,
  // Writeback
  output logic                           result_valid,
  output logic [simd_pkg::VEC_W-1:0]     result_data,
  output logic                           result_from_memory,
  output logic                           illegal_op
);
  import simd_pkg::*;

  typedef struct packed {
    logic              valid;
    logic [VEC_W-1:0]  data;
    logic              mem;
    logic              bad;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // ==========================================================
  // Opcode decode, shared by classification and validity
  function automatic op_e decode_op(input logic [OPC_W-1:0] o);
    case (o)
      OPC_PACK_SB: decode_op = op_pack_sb;
      OPC_PACK_UB: decode_op = op_pack_ub;
      OPC_ADD_B:   decode_op = op_add_b;
      OPC_ADD_W:   decode_op = op_add_w;
      OPC_ADD_D:   decode_op = op_add_d;
      OPC_ADDS_SB: decode_op = op_adds_sb;
      OPC_ADDS_SW: decode_op = op_adds_sw;
      OPC_ADDS_UB: decode_op = op_adds_ub;
      OPC_ADDS_UW: decode_op = op_adds_uw;
      OPC_AND:     decode_op = op_and;
      OPC_ANDN:    decode_op = op_andn;
      OPC_CMPEQ_B: decode_op = op_eq_b;
      OPC_CMPEQ_W: decode_op = op_eq_w;
      OPC_CMPEQ_D: decode_op = op_eq_d;
      OPC_CMPGT_B: decode_op = op_gt_b;
      OPC_CMPGT_D: decode_op = op_gt_d;
      default:     decode_op = op_none;
    endcase
  endfunction

  // Narrow one signed word to a byte with signed or unsigned clamp
  function automatic logic [BYTE_W-1:0] narrow(input logic [WORD_W-1:0] w,
                                               input logic uns);
    logic signed [WORD_W-1:0] s;
    s = signed'(w);
    if (uns) begin
      if (s < 0)
        narrow = 8'h00;
      else if (s > 16'sh00ff)
        narrow = 8'hff;
      else
        narrow = w[BYTE_W-1:0];
    end else begin
      if (s > 16'sh007f)
        narrow = 8'h7f;
      else if (s < -16'sh0080)
        narrow = 8'h80;
      else
        narrow = w[BYTE_W-1:0];
    end
  endfunction

  op_e              op;
  logic [VEC_W-1:0] dst;
  logic [VEC_W-1:0] src;
  logic             sat_b;
  logic             sat_w;
  logic             sgn_b;
  logic             sgn_w;
  logic [VEC_W-1:0] sum_b;
  logic [VEC_W-1:0] sum_w;
  logic [VEC_W-1:0] sum_d;
  logic [VEC_W-1:0] eq_b;
  logic [VEC_W-1:0] eq_w;
  logic [VEC_W-1:0] eq_d;
  logic [VEC_W-1:0] gt_b;
  logic [VEC_W-1:0] gt_d;
  logic [VEC_W-1:0] pack_v;

  // ==========================================================
  // Operand selection: mod 11 takes the register, else memory
  assign op    = decode_op(opcode);
  assign dst   = destination_vector_register;
  assign src   = (mod_field == MOD_REG) ? source_vector_register : memory_operand;
  assign sat_b = (op == op_adds_sb) || (op == op_adds_ub);
  assign sgn_b = (op == op_adds_sb);
  assign sat_w = (op == op_adds_sw) || (op == op_adds_uw);
  assign sgn_w = (op == op_adds_sw);

  // ==========================================================
  // Byte lanes: add, equality, signed greater-than
  genvar gi;
  generate
    for (gi = 0; gi < N_BYTES; gi++) begin : g_byte
      simd_lane_sat #(.W(BYTE_W)) u_add (
        .a         (dst[gi*BYTE_W +: BYTE_W]),
        .b         (src[gi*BYTE_W +: BYTE_W]),
        .sat_en    (sat_b),
        .signed_en (sgn_b),
        .sum       (sum_b[gi*BYTE_W +: BYTE_W])
      );
      assign eq_b[gi*BYTE_W +: BYTE_W] =
        {BYTE_W{dst[gi*BYTE_W +: BYTE_W] == src[gi*BYTE_W +: BYTE_W]}};
      assign gt_b[gi*BYTE_W +: BYTE_W] =
        {BYTE_W{signed'(dst[gi*BYTE_W +: BYTE_W]) >
                signed'(src[gi*BYTE_W +: BYTE_W])}};
    end
    // Word lanes: add, equality, and the two pack halves
    for (gi = 0; gi < N_WORDS; gi++) begin : g_word
      simd_lane_sat #(.W(WORD_W)) u_add (
        .a         (dst[gi*WORD_W +: WORD_W]),
        .b         (src[gi*WORD_W +: WORD_W]),
        .sat_en    (sat_w),
        .signed_en (sgn_w),
        .sum       (sum_w[gi*WORD_W +: WORD_W])
      );
      assign eq_w[gi*WORD_W +: WORD_W] =
        {WORD_W{dst[gi*WORD_W +: WORD_W] == src[gi*WORD_W +: WORD_W]}};
      // Destination words fill the low bytes, source words the high
      assign pack_v[gi*BYTE_W +: BYTE_W] =
        narrow(dst[gi*WORD_W +: WORD_W], op == op_pack_ub);
      assign pack_v[(gi+N_WORDS)*BYTE_W +: BYTE_W] =
        narrow(src[gi*WORD_W +: WORD_W], op == op_pack_ub);
    end
    // Doubleword lanes: wrap add, equality, signed greater-than
    for (gi = 0; gi < N_DWORDS; gi++) begin : g_dword
      assign sum_d[gi*DWORD_W +: DWORD_W] =
        dst[gi*DWORD_W +: DWORD_W] + src[gi*DWORD_W +: DWORD_W];
      assign eq_d[gi*DWORD_W +: DWORD_W] =
        {DWORD_W{dst[gi*DWORD_W +: DWORD_W] == src[gi*DWORD_W +: DWORD_W]}};
      assign gt_d[gi*DWORD_W +: DWORD_W] =
        {DWORD_W{signed'(dst[gi*DWORD_W +: DWORD_W]) >
                 signed'(src[gi*DWORD_W +: DWORD_W])}};
    end
  endgenerate

  // ==========================================================
  // Result select; unknown opcodes flag illegal and leave data
  // unchanged so a stray issue never corrupts a written lane
  always_comb begin
    st_next       = st_reg;
    st_next.valid = issue_valid;
    st_next.mem   = issue_valid && (mod_field != MOD_REG);
    st_next.bad   = issue_valid && (op == op_none);
    if (issue_valid) begin
      case (op)
        op_pack_sb, op_pack_ub: st_next.data = pack_v;
        op_add_b, op_adds_sb, op_adds_ub: st_next.data = sum_b;
        op_add_w, op_adds_sw, op_adds_uw: st_next.data = sum_w;
        op_add_d: st_next.data = sum_d;
        op_and:   st_next.data = dst & src;
        op_andn:  st_next.data = ~dst & src;
        op_eq_b:  st_next.data = eq_b;
        op_eq_w:  st_next.data = eq_w;
        op_eq_d:  st_next.data = eq_d;
        op_gt_b:  st_next.data = gt_b;
        op_gt_d:  st_next.data = gt_d;
        default:  st_next.data = st_reg.data;
      endcase
    end
  end

  // State register; one clock latency for every form
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign result_valid       = st_reg.valid;
  assign result_data        = st_reg.data;
  assign result_from_memory = st_reg.mem;
  assign illegal_op         = st_reg.bad;

  // ==========================================================
  // Checks
  latency_one_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid |=> result_valid) else $error("result not one clock after issue");
  and_result_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_AND |=> result_data == $past(dst & src))
    else $error("and result wrong");
  andn_result_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ANDN |=> result_data == $past(~dst & src))
    else $error("and-not result wrong");
  add_wrap_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ADD_B |=>
      result_data[7:0] == 8'($past(dst[7:0]) + $past(src[7:0])))
    else $error("byte wrap add wrong");
  sat_ub_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ADDS_UB && ({1'b0, dst[7:0]} + {1'b0, src[7:0]}) > 9'h0ff
      |=> result_data[7:0] == 8'hff) else $error("unsigned byte clamp missing");
  sat_sw_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ADDS_SW && !dst[15] && !src[15] &&
      17'(dst[15:0]) + 17'(src[15:0]) > 17'h07fff
      |=> result_data[15:0] == 16'h7fff) else $error("signed word clamp missing");
  eq_word_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_CMPEQ_W |=>
      result_data[15:0] == ($past(dst[15:0] == src[15:0]) ? 16'hffff : 16'h0000))
    else $error("word equality mask wrong");
  gt_dword_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_CMPGT_D |=>
      result_data[63:32] == ($past(signed'(dst[63:32]) > signed'(src[63:32])) ?
                             32'hffffffff : 32'h00000000))
    else $error("dword greater-than mask wrong");
  pack_sb_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_PACK_SB && !dst[15] && dst[15:0] > 16'h007f
      |=> result_data[7:0] == 8'h7f) else $error("signed pack clamp missing");

  // ==========================================================
  // Handshake and flag checks
  // A quiet cycle must not leave a stale valid behind
  valid_drop_a: assert property (@(posedge core_clk) disable iff (rst)
    !issue_valid |=> !result_valid) else $error("valid without issue");
  // The memory flag follows the mod field of the issuing cycle
  mem_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid |=> result_from_memory == $past(mod_field != MOD_REG))
    else $error("memory form flag wrong");
  // Unsupported opcodes raise the flag alongside valid
  illegal_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid |=> illegal_op == $past(op == op_none))
    else $error("illegal flag wrong");
  // An unsupported opcode must leave the last result untouched
  illegal_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && op == op_none |=> $stable(result_data))
    else $error("illegal opcode changed data");
  // Memory form must take the memory operand, not the register
  and_mem_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_AND && mod_field != MOD_REG |=>
      result_data == $past(destination_vector_register & memory_operand))
    else $error("memory form and wrong");
  // Register form must take the register source
  andn_reg_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ANDN && mod_field == MOD_REG |=>
      result_data == $past(~destination_vector_register & source_vector_register))
    else $error("register form and-not wrong");

  // ==========================================================
  // Wrap-around adds; the top byte and dword lanes show that no carry leaks in
  add_byte_top_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ADD_B |=>
      result_data[63:56] == 8'($past(dst[63:56]) + $past(src[63:56])))
    else $error("top byte wrap add wrong");
  add_word_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ADD_W |=>
      result_data[15:0] == 16'($past(dst[15:0]) + $past(src[15:0])))
    else $error("word wrap add wrong");
  add_dword_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ADD_D |=>
      result_data[63:32] == 32'($past(dst[63:32]) + $past(src[63:32])))
    else $error("dword wrap add wrong");

  // ==========================================================
  // Saturating adds, both limits and the untouched in-range case
  // Two positives overflowing must pin at the positive limit
  sat_sb_hi_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ADDS_SB && !dst[63] && !src[63] &&
      ({1'b0, dst[63:56]} + {1'b0, src[63:56]}) > 9'h07f
      |=> result_data[63:56] == 8'h7f) else $error("signed byte high clamp missing");
  // Two negatives whose sum drops below the range pin at the negative limit
  sat_sb_lo_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ADDS_SB && dst[55] && src[55] &&
      ({1'b0, dst[55:48]} + {1'b0, src[55:48]}) < 9'h180
      |=> result_data[55:48] == 8'h80) else $error("signed byte low clamp missing");
  sat_sw_lo_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ADDS_SW && dst[31] && src[31] &&
      ({1'b0, dst[31:16]} + {1'b0, src[31:16]}) < 17'h18000
      |=> result_data[31:16] == 16'h8000) else $error("signed word low clamp missing");
  sat_uw_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ADDS_UW &&
      ({1'b0, dst[31:16]} + {1'b0, src[31:16]}) > 17'h0ffff
      |=> result_data[31:16] == 16'hffff) else $error("unsigned word clamp missing");
  // Clamping must never touch a sum that already fits
  sat_ub_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ADDS_UB &&
      ({1'b0, dst[15:8]} + {1'b0, src[15:8]}) <= 9'h0ff
      |=> result_data[15:8] == 8'($past(dst[15:8]) + $past(src[15:8])))
    else $error("unsigned byte in-range sum changed");
  // Operands of unlike sign can never overflow
  sat_sw_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_ADDS_SW && (dst[47] != src[47])
      |=> result_data[47:32] == 16'($past(dst[47:32]) + $past(src[47:32])))
    else $error("signed word in-range sum changed");

  // ==========================================================
  // Compare masks
  eq_byte_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_CMPEQ_B |=>
      result_data[7:0] == ($past(dst[7:0] == src[7:0]) ? 8'hff : 8'h00))
    else $error("byte equality mask wrong");
  eq_dword_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_CMPEQ_D |=>
      result_data[31:0] == ($past(dst[31:0] == src[31:0]) ?
                            32'hffffffff : 32'h00000000))
    else $error("dword equality mask wrong");
  // Signed view: a set top bit is the smaller value
  gt_byte_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_CMPGT_B |=>
      result_data[63:56] == ($past(signed'(dst[63:56]) > signed'(src[63:56])) ?
                             8'hff : 8'h00))
    else $error("byte greater-than mask wrong");

  // ==========================================================
  // Packing: clamps and the source half
  pack_sb_lo_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_PACK_SB && dst[63] && dst[63:48] < 16'hff80
      |=> result_data[31:24] == 8'h80) else $error("signed pack low clamp missing");
  // Negative words have no unsigned byte, so they pin at zero
  pack_ub_neg_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_PACK_UB && dst[63]
      |=> result_data[31:24] == 8'h00) else $error("unsigned pack zero clamp missing");
  // An in-range source word lands unchanged in the upper half
  pack_src_half_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && opcode == OPC_PACK_SB && (src[15:8] == {8{src[7]}})
      |=> result_data[39:32] == $past(src[7:0])) else $error("pack source half wrong");
endmodule
`default_nettype wire

/* File: simd_issue_model.sv */
// Decoder and vector register file model feeding the SIMD datapath
`timescale 1ns/1ps
`default_nettype none
module simd_issue_model (
  // Clock
  input  wire logic                        core_clk,
  // Issue to datapath
  output logic                             issue_valid,
  output logic [simd_pkg::OPC_W-1:0]       opcode,
  output logic [1:0]                       mod_field,
  output logic [simd_pkg::VEC_W-1:0]       destination_vector_register,
  output logic [simd_pkg::VEC_W-1:0]       source_vector_register,
  output logic [simd_pkg::VEC_W-1:0]       memory_operand
);
  import simd_pkg::*;
  // ==========================================================
  // Idle state at time zero
  initial begin
    issue_valid = 1'b0;
    opcode = 16'h0000;
    mod_field = 2'h0;
    destination_vector_register = 64'h0;
    source_vector_register = 64'h0;
    memory_operand = 64'h0;
  end
  // Present one operation after a falling edge; held until the next call
  task automatic drive(input logic [15:0] op, input logic [1:0] md,
                       input logic [63:0] d, input logic [63:0] s);
    @(negedge core_clk);
    issue_valid = 1'b1;
    opcode = op;
    mod_field = md;
    destination_vector_register = d;
    // The unused source carries inverted data, so a wrong pick shows
    source_vector_register = (md == MOD_REG) ? s : ~s;
    memory_operand = (md == MOD_REG) ? ~s : s;
  endtask
  // Valid drops and the opcode and operand lines flip, mod_field holds, since a stale value must not look valid
  task automatic idle();
    @(negedge core_clk);
    issue_valid = 1'b0;
    opcode = ~opcode;
    destination_vector_register = ~destination_vector_register;
    source_vector_register = ~source_vector_register;
    memory_operand = ~memory_operand;
  endtask
endmodule
`default_nettype wire

/* File: packed_simd_add_logic_compare_tb.sv */
// Self-checking testbench for the packed SIMD execution unit
`timescale 1ns/1ps
`default_nettype none
module packed_simd_add_logic_compare_tb;
  import simd_pkg::*;
  // ==========================================================
  // Signals
  logic        core_clk;
  logic        rst;
  logic        issue_valid;
  logic [15:0] opcode;
  logic [1:0]  mod_field;
  logic [63:0] dst;
  logic [63:0] src;
  logic [63:0] mem;
  logic        result_valid;
  logic [63:0] result_data;
  logic        result_from_memory;
  logic        illegal_op;
  int          fails = 0;
  int          checks_done = 0;
  // ==========================================================
  // Instances
  simd_issue_model simd_issue_model_i (.core_clk(core_clk), .issue_valid(issue_valid),
    .opcode(opcode), .mod_field(mod_field), .destination_vector_register(dst),
    .source_vector_register(src), .memory_operand(mem));
  simd_exec simd_exec_i (.core_clk(core_clk), .rst(rst), .issue_valid(issue_valid),
    .opcode(opcode), .mod_field(mod_field), .destination_vector_register(dst),
    .source_vector_register(src), .memory_operand(mem), .result_valid(result_valid),
    .result_data(result_data), .result_from_memory(result_from_memory),
    .illegal_op(illegal_op));
  // 25 MHz clock
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;
  // ==========================================================
  // Compare tasks and verdict
  task automatic check64(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check1(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Reference model: lane width w and mode m per opcode
  function automatic longint fld(input logic [63:0] v, input int i, input int w, input bit sg);
    longint x;
    x = longint'((v >> (i * w)) & ((64'h1 << w) - 64'h1));
    if (sg && x[w-1]) x = x - (longint'(1) << w);
    return x;
  endfunction
  function automatic longint clamp(input longint v, input longint lo, input longint hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  function automatic logic [63:0] ref_op(input logic [15:0] op, input logic [63:0] d,
                                         input logic [63:0] s);
    logic [63:0] r;
    int          wm;
    int          w;
    int          m;
    longint      a;
    longint      b;
    longint      v;
    longint      lo;
    longint      hi;
    case (op)
      OPC_ADD_B: wm = 80;
      OPC_ADD_W: wm = 160;
      OPC_ADD_D: wm = 320;
      OPC_ADDS_SB: wm = 81;
      OPC_ADDS_SW: wm = 161;
      OPC_ADDS_UB: wm = 82;
      OPC_ADDS_UW: wm = 162;
      OPC_CMPEQ_B: wm = 83;
      OPC_CMPEQ_W: wm = 163;
      OPC_CMPEQ_D: wm = 323;
      OPC_CMPGT_B: wm = 84;
      OPC_CMPGT_D: wm = 324;
      OPC_PACK_SB: wm = 165;
      OPC_PACK_UB: wm = 166;
      OPC_AND: wm = 7;
      default: wm = 8;
    endcase
    w = wm / 10;
    m = wm % 10;
    if (m == 7) return d & s;
    if (m == 8) return ~d & s;
    r = 64'h0;
    for (int i = 0; i < 64 / w; i++) begin
      a = fld(d, i, w, m != 2);
      b = fld(s, i, w, m != 2);
      hi = (m == 2) ? (longint'(1) << w) - 1 : (longint'(1) << (w - 1)) - 1;
      lo = (m == 2) ? 0 : -hi - 1;
      v = (m == 1 || m == 2) ? clamp(a + b, lo, hi) : a + b;
      if (m == 3) v = (a == b) ? -1 : 0;
      if (m == 4) v = (a > b) ? -1 : 0;
      if (m >= 5) begin
        r[i*8+:8] = 8'(clamp(a, (m == 5) ? -128 : 0, (m == 5) ? 127 : 255));
        r[32+i*8+:8] = 8'(clamp(b, (m == 5) ? -128 : 0, (m == 5) ? 127 : 255));
      end else begin
        r = r | ((64'(v) & ((64'h1 << w) - 64'h1)) << (i * w));
      end
    end
    return r;
  endfunction
  // One issue, then the one-cycle answer is judged at the next falling edge
  task automatic run(input logic [15:0] op, input logic [1:0] md, input logic [63:0] d,
                     input logic [63:0] s);
    simd_issue_model_i.drive(op, md, d, s);
    simd_issue_model_i.idle();
    check1("result_valid", 1'b1, result_valid);
    check1("result_from_memory", md != MOD_REG, result_from_memory);
    check1("illegal_op", 1'b0, illegal_op);
    check64("result_data", ref_op(op, d, s), result_data);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_pack();
    run(OPC_PACK_SB, MOD_REG, 64'h8000_7fff_ff80_0080, 64'h00ff_ffff_0100_007f);
    run(OPC_PACK_UB, 2'h0, 64'h8000_7fff_ff80_0080, 64'h00ff_ffff_0100_007f);
    run(OPC_PACK_UB, MOD_REG, 64'h0001_00fe_0000_00ff, 64'h0100_0080_8000_0005);
  endtask
  task automatic t_add_wrap();
    logic [15:0] ops [3] = '{OPC_ADD_B, OPC_ADD_W, OPC_ADD_D};
    foreach (ops[k]) run(ops[k], 2'(k), 64'h7fff_ffff_80ff_ff01, 64'h0001_0001_8001_01ff);
  endtask
  task automatic t_add_sat();
    logic [15:0] ops [4] = '{OPC_ADDS_SB, OPC_ADDS_SW, OPC_ADDS_UB, OPC_ADDS_UW};
    foreach (ops[k]) run(ops[k], MOD_REG, 64'h7f80_ff01_8000_7fff, 64'h0180_0101_ffff_0001);
  endtask
  task automatic t_logic();
    for (int md = 0; md < 4; md++) begin
      run(OPC_AND, 2'(md), 64'hf0f0_1234_ffff_0000, 64'h0ff0_ff00_a5a5_ffff);
      run(OPC_ANDN, 2'(md), 64'hf0f0_1234_ffff_0000, 64'h0ff0_ff00_a5a5_ffff);
    end
  endtask
  task automatic t_compare();
    logic [15:0] ops [5] = '{OPC_CMPEQ_B, OPC_CMPEQ_W, OPC_CMPEQ_D, OPC_CMPGT_B, OPC_CMPGT_D};
    foreach (ops[k]) run(ops[k], 2'(k), 64'h8001_7f00_1234_ff80, 64'h7f01_8000_1234_0080);
  endtask
  // Back-to-back issue, then an unsupported opcode keeps the old result
  task automatic t_stream();
    logic [63:0] e;
    e = ref_op(OPC_ADD_B, 64'h0102_0304_0506_0708, 64'hffff_ffff_ffff_ffff);
    simd_issue_model_i.drive(OPC_ADD_B, MOD_REG, 64'h0102_0304_0506_0708, 64'hffff_ffff_ffff_ffff);
    simd_issue_model_i.drive(16'h0f65, MOD_REG, 64'h1111_2222_3333_4444, 64'h0);
    check64("stream_first", e, result_data);
    simd_issue_model_i.idle();
    check1("stream_valid", 1'b1, result_valid);
    check1("stream_illegal", 1'b1, illegal_op);
    check64("stream_held", e, result_data);
    @(negedge core_clk);
    check1("idle_valid", 1'b0, result_valid);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    repeat (8) @(posedge core_clk);
    check1("reset_valid", 1'b0, result_valid);
    check64("reset_data", 64'h0, result_data);
    @(negedge core_clk);
    rst = 1'b0;
    t_pack();
    t_add_wrap();
    t_add_sat();
    t_logic();
    t_compare();
    t_stream();
    finish_test();
  end
  // Watchdog, far beyond the few dozen cycles the scenarios need
  initial begin
    #20000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
